// File: rtl/dbg_pkg.sv
/*
  Constants, types and helper functions shared by the debug access and trace block.
  Assumes a single 100 MHz system clock and that pin-side logic samples its inputs.
*/
package dbg_pkg;
  localparam int MCLK_HZ = 100_000_000;
  localparam int KEY_WIN_NS = 8000; // Key window after reset
  localparam int KEY_WIN_CYC = KEY_WIN_NS * (MCLK_HZ / 1_000_000) / 1000; // Longest time, rounded down
  localparam int TCK_MAX_HZ = 8_000_000; // Fastest test clock
  localparam int TCK_MIN_CYC = MCLK_HZ / TCK_MAX_HZ; // Rounded down to allow sampling jitter
  localparam int KEY_LEN = 16;
  localparam logic [KEY_LEN-1:0] KEY_SEQ = 16'h6a3c; // Arbitrary acquisition pattern
  localparam int WIN_W = 10;
  localparam int TCK_CNT_W = 4;
  localparam int NUM_BP = 8;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam int TRACE_FULL_DEPTH = 1000; // Instructions with PC, accumulator and selected register
  localparam int TRACE_PC_DEPTH = 2000; // Instructions with PC only
  localparam int TRACE_IDX_W = 11;
  localparam int TRACE_WORD_W = 10;
  localparam int SEQ_W = 3;
  localparam logic [2:0] GPIO_NONE = 3'h0;
  localparam logic [2:0] GPIO_JTAG4 = 3'h4;
  localparam logic [2:0] GPIO_JTAG5 = 3'h5;
  localparam logic [2:0] GPIO_SWD = 3'h2;
  localparam logic [2:0] GPIO_VIEWER = 3'h1;

  typedef logic [ADDR_W-1:0] addr_type;

  typedef enum logic [2:0]
  {
    CPU_RUN = 3'b001,
    CPU_HALT = 3'b010,
    CPU_STEP = 3'b100
  } cpu_state_type;

  // Inclusive address range test
  function automatic logic in_range(input addr_type a, input addr_type lo, input addr_type hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range
endpackage : dbg_pkg

// File: rtl/acq_if.sv
/*
  Carrier between the top block and each key detector.
  Assumes both ends run on the same system clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface acq_if;
  logic armed; // Key window still open
  logic match; // Key seen on this pair, one-cycle pulse
  logic clk_rise; // Sampled pin clock rose
  logic data; // Sampled pin data
  modport det(input armed, output match, output clk_rise, output data);
  modport top(output armed, input match, input clk_rise, input data);
endinterface : acq_if
`default_nettype wire

// File: rtl/key_detector.sv
/*
  Samples one candidate pin pair, finds clock edges and spots the acquisition key.
  Assumes pin inputs are asynchronous to the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module key_detector
  import dbg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_pin_clk,
  input wire logic i_pin_data,
  acq_if.det acq
);
  logic [1:0] clk_sync; // Clock synchroniser, bit 0 is the first stage
  logic [1:0] data_sync; // Data synchroniser
  logic clk_last; // Previous synchronised clock
  logic [KEY_LEN-1:0] shift; // Recent bits, newest at bit 0

  // Two stages before anything looks at the pins
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      clk_sync <= 2'h0;
      data_sync <= 2'h0;
      clk_last <= 1'b0;
    end
    else
    begin
      clk_sync <= {clk_sync[0], i_pin_clk};
      data_sync <= {data_sync[0], i_pin_data};
      clk_last <= clk_sync[1];
    end
  end

  assign acq.clk_rise = clk_sync[1] && !clk_last; // Debugger drives this clock
  assign acq.data = data_sync[1];

  // Shift data on each clock rise, whether or not the window is open
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      shift <= '0;
    else if (acq.clk_rise)
      shift <= {shift[KEY_LEN-2:0], data_sync[1]};
  end

  // Match only counts inside the key window
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      acq.match <= 1'b0;
    else
      acq.match <= acq.armed && acq.clk_rise && ({shift[KEY_LEN-2:0], data_sync[1]} == KEY_SEQ);
  end
endmodule : key_detector
`default_nettype wire

// File: rtl/debug_port_access_and_trace.sv
/*
  Debug port selection, key acquisition, security gating, CPU halt control,
  breakpoints and instruction trace buffer.
  Assumes the JTAG and SWD protocol engines and the CPU sit outside on the
  system clock; only the pin inputs are asynchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module debug_port_access_and_trace
  import dbg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  // Test port / first serial pair pins
  input wire logic i_tck,
  input wire logic i_tms_in,
  output logic o_tms_out,
  output logic o_tms_oe,
  output logic o_tdo,
  output logic o_tdo_oe,
  // USB pair pins, second serial pair
  input wire logic i_usb_dm_in,
  input wire logic i_usb_dp_in,
  output logic o_usb_dp_out,
  output logic o_usb_dp_oe,
  // Configuration and control levels
  input wire logic i_security_lock,
  input wire logic i_jtag_cfg_disable,
  input wire logic i_trst_used,
  input wire logic i_fw_debug_enable,
  input wire logic i_jtag_disable,
  input wire logic i_jtag_swd_enable,
  input wire logic i_swd_disable,
  input wire logic i_swd_jtag_enable,
  input wire logic i_viewer_enable,
  input wire logic i_viewer_bit,
  // Protocol engine side
  input wire logic i_jtag_tdo,
  input wire logic i_swd_dout,
  input wire logic i_swd_doe,
  output logic o_swd_clk_rise,
  output logic o_swd_din,
  output logic o_jtag_active,
  output logic o_swd_on_jtag_pins,
  output logic o_swd_on_usb_pins,
  output logic o_bscan_allow,
  output logic o_viewer_active,
  output logic [2:0] o_gpio_claim,
  output logic o_tck_overrate,
  output logic o_debug_on,
  // Debugger commands
  input wire logic i_halt_req,
  input wire logic i_step_req,
  input wire logic i_resume_req,
  input wire logic i_dbg_access_req,
  output logic o_dbg_access_grant,
  // Breakpoints
  input wire logic [NUM_BP-1:0] i_bp_en,
  input wire logic [NUM_BP-1:0][ADDR_W-1:0] i_bp_addr,
  input wire logic i_seq_mode,
  input wire logic [SEQ_W-1:0] i_seq_last,
  input wire logic i_mbp_en,
  input wire logic [ADDR_W-1:0] i_mbp_addr,
  input wire logic [DATA_W-1:0] i_mbp_data,
  // CPU side
  input wire logic i_cpu_retire,
  input wire logic [ADDR_W-1:0] i_cpu_pc,
  input wire logic [DATA_W-1:0] i_cpu_accum,
  input wire logic [DATA_W-1:0] i_cpu_sel_reg,
  input wire logic i_mem_access,
  input wire logic [ADDR_W-1:0] i_mem_addr,
  input wire logic [DATA_W-1:0] i_mem_data,
  output logic o_cpu_halt,
  // Trace control and readout
  input wire logic i_trace_enable,
  input wire logic i_trace_pc_only,
  input wire logic [ADDR_W-1:0] i_trace_trig_addr,
  input wire logic i_trace_window_en,
  input wire logic [ADDR_W-1:0] i_trace_lo,
  input wire logic [ADDR_W-1:0] i_trace_hi,
  input wire logic i_trace_halt_on_full,
  input wire logic [TRACE_WORD_W-1:0] i_trace_rd_index,
  output logic [2*ADDR_W-1:0] o_trace_word,
  output logic [TRACE_IDX_W-1:0] o_trace_count,
  output logic o_trace_wrapped
);
  acq_if jtag_acq(); // Detector on the test pins
  acq_if usb_acq(); // Detector on the USB pins

  logic captured; // Straps taken after reset release
  logic lock; // Security lock as sampled
  logic locked; // Lock, or not yet known
  logic jtag_on; // Test port owns its pins
  logic swd_jtag; // Serial port on test pins
  logic swd_usb; // Serial port on USB pins
  logic swd_any; // Serial port active anywhere
  logic [WIN_W-1:0] win_cnt; // Cycles since reset release
  logic odc_en; // Firmware enabled on_chip_debug_circuits
  logic debug_on; // Debug features usable
  logic viewer_on; // single_wire_viewer_output active
  logic [TCK_CNT_W-1:0] tck_cnt; // Cycles since last test clock rise
  logic tck_seen; // A first rise has been seen
  cpu_state_type state; // CPU halt control
  cpu_state_type next_state;
  logic [NUM_BP-1:0] pc_hit; // Per comparator hit
  logic [SEQ_W-1:0] seq_idx; // Next breakpoint expected in sequence
  logic bp_halt; // A breakpoint condition asks for halt
  logic mbp_hit; // Memory access breakpoint hit
  logic trace_armed; // Waiting for the trigger
  logic trace_run; // Trigger seen, recording
  logic trace_full; // Buffer holds its full depth
  logic trace_halt; // Full with the halt policy
  logic trace_wr; // Record this instruction
  logic [TRACE_IDX_W-1:0] wp; // Next write slot
  logic [TRACE_IDX_W-1:0] depth; // Depth for the current mode
  logic [2*ADDR_W-1:0] mem [TRACE_FULL_DEPTH]; // Trace storage, PC-only packs two per word

  key_detector u_jtag_det (.i_mclk(i_mclk), .i_rst(i_rst), .i_pin_clk(i_tck), .i_pin_data(i_tms_in),
                           .acq(jtag_acq.det));
  key_detector u_usb_det (.i_mclk(i_mclk), .i_rst(i_rst), .i_pin_clk(i_usb_dm_in), .i_pin_data(i_usb_dp_in),
                          .acq(usb_acq.det));

  // Key window counter; saturates so the window never reopens without reset
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      win_cnt <= '0;
    else if (win_cnt < WIN_W'(KEY_WIN_CYC))
      win_cnt <= win_cnt + 1'b1;
  end

  assign jtag_acq.armed = (win_cnt < WIN_W'(KEY_WIN_CYC)) && !locked;
  assign usb_acq.armed = jtag_acq.armed;

  // Lock is caught one edge after release; until then treat as locked
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      captured <= 1'b0;
      lock <= 1'b0;
    end
    else if (!captured)
    begin
      captured <= 1'b1;
      lock <= i_security_lock;
    end
  end

  assign locked = lock || !captured;

  // Port ownership; serial port never lives on both pairs
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      jtag_on <= 1'b1; // Unconfigured default
      swd_jtag <= 1'b0; // Idle until key or enable from the test port
      swd_usb <= 1'b0;
    end
    else if (!captured)
      jtag_on <= !i_jtag_cfg_disable && !i_security_lock;
    else if (locked)
    begin
      jtag_on <= 1'b0;
      swd_jtag <= 1'b0;
      swd_usb <= 1'b0;
    end
    else if (!swd_any && jtag_acq.match)
    begin
      swd_jtag <= 1'b1; // Test pair wins a tie
      jtag_on <= 1'b0;
    end
    else if (!swd_any && usb_acq.match)
      swd_usb <= 1'b1;
    else if (jtag_on && !swd_any && i_jtag_swd_enable)
    begin
      swd_jtag <= 1'b1; // Enabled from the test port
      jtag_on <= 1'b0;
    end
    else if (swd_any && i_swd_jtag_enable)
    begin
      jtag_on <= 1'b1; // Serial port restores test port
      swd_jtag <= 1'b0; // Shares TMS/TCK, so it must give way
    end
    else if (i_swd_disable)
    begin
      swd_jtag <= 1'b0; // Pins back to GPIO
      swd_usb <= 1'b0;
    end
    else if (i_jtag_disable)
      jtag_on <= 1'b0;
  end

  assign swd_any = swd_jtag || swd_usb;

  // Firmware enable is sticky until reset
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      odc_en <= 1'b0;
    else if (i_fw_debug_enable)
      odc_en <= 1'b1;
  end

  assign debug_on = odc_en && !locked && (jtag_on || swd_any);
  assign viewer_on = i_viewer_enable && !jtag_on && !locked;
  assign o_debug_on = debug_on;
  assign o_jtag_active = jtag_on;
  assign o_swd_on_jtag_pins = swd_jtag;
  assign o_swd_on_usb_pins = swd_usb;
  assign o_bscan_allow = jtag_on; // No scan chains over the serial port
  assign o_viewer_active = viewer_on;
  // Access works whether the CPU is in reset or asleep
  assign o_dbg_access_grant = debug_on && i_dbg_access_req;

  // Serial data and clock from whichever pair holds the port
  assign o_swd_clk_rise = swd_jtag ? jtag_acq.clk_rise : (swd_usb && usb_acq.clk_rise);
  assign o_swd_din = swd_jtag ? jtag_acq.data : (swd_usb && usb_acq.data);

  // Pin claim per configuration; USB pins are not GPIO
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_gpio_claim <= GPIO_NONE;
    else if (jtag_on)
      o_gpio_claim <= i_trst_used ? GPIO_JTAG5 : GPIO_JTAG4;
    else
      o_gpio_claim <= (swd_jtag ? GPIO_SWD : GPIO_NONE) + (viewer_on ? GPIO_VIEWER : GPIO_NONE);
  end

  // Pin drivers are registered; serial data driven only by the owning pair
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_tms_out <= 1'b0;
      o_tms_oe <= 1'b0;
      o_usb_dp_out <= 1'b0;
      o_usb_dp_oe <= 1'b0;
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end
    else
    begin
      o_tms_out <= i_swd_dout;
      o_tms_oe <= swd_jtag && i_swd_doe;
      o_usb_dp_out <= i_swd_dout;
      o_usb_dp_oe <= swd_usb && i_swd_doe;
      o_tdo <= viewer_on ? i_viewer_bit : i_jtag_tdo;
      o_tdo_oe <= viewer_on || jtag_on;
    end
  end

  // Test clock rate watch; flag is sticky so a short burst is not missed
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      tck_cnt <= '0;
      tck_seen <= 1'b0;
      o_tck_overrate <= 1'b0;
    end
    else if (jtag_on && jtag_acq.clk_rise)
    begin
      tck_cnt <= '0;
      tck_seen <= 1'b1;
      if (tck_seen && (tck_cnt < TCK_CNT_W'(TCK_MIN_CYC - 1)))
        o_tck_overrate <= 1'b1;
    end
    else if (tck_cnt != '1)
      tck_cnt <= tck_cnt + 1'b1;
  end

  // Program address comparators
  always_comb
  begin
    for (int i = 0; i < NUM_BP; i++)
      pc_hit[i] = debug_on && i_cpu_retire && i_bp_en[i] && (i_cpu_pc == i_bp_addr[i]);
  end

  assign mbp_hit = debug_on && i_mbp_en && i_mem_access && (i_mem_addr == i_mbp_addr)
                   && (i_mem_data == i_mbp_data);
  assign bp_halt = i_seq_mode ? (pc_hit[seq_idx] && (seq_idx == i_seq_last)) : (|pc_hit);

  // Sequence walks once through in order; hits out of order are ignored
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      seq_idx <= '0;
    else if (!i_seq_mode || !debug_on)
      seq_idx <= '0;
    else if (pc_hit[seq_idx])
      seq_idx <= (seq_idx == i_seq_last) ? '0 : seq_idx + 1'b1; // Non-recursive restart
  end

  // Halt and step control
  always_comb
  begin
    next_state = state;
    unique case (state)
      CPU_RUN:
        if (i_halt_req || bp_halt || mbp_hit || trace_halt)
          next_state = CPU_HALT;
      CPU_HALT:
        if (i_resume_req)
          next_state = CPU_RUN;
        else if (i_step_req)
          next_state = CPU_STEP;
      CPU_STEP:
        if (i_cpu_retire)
          next_state = CPU_HALT; // One instruction then stop
      default:
        next_state = CPU_RUN; // Illegal code recovers to run
    endcase
    if (!debug_on)
      next_state = CPU_RUN; // Circuits off never hold the CPU
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      state <= CPU_RUN;
    else
      state <= next_state;
  end

  assign o_cpu_halt = (state == CPU_HALT);

  // Trace trigger: armed by enable only while debug is off; run from the first trigger match
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      trace_armed <= 1'b0;
      trace_run <= 1'b0;
    end
    else if (!i_trace_enable || !debug_on)
    begin
      trace_armed <= i_trace_enable;
      trace_run <= 1'b0;
    end
    else if (trace_armed && i_cpu_retire && (i_cpu_pc == i_trace_trig_addr))
    begin
      trace_armed <= 1'b0;
      trace_run <= 1'b1;
    end
  end

  assign depth = i_trace_pc_only ? TRACE_IDX_W'(TRACE_PC_DEPTH) : TRACE_IDX_W'(TRACE_FULL_DEPTH);
  assign trace_full = (o_trace_count == depth);
  assign trace_halt = trace_full && i_trace_halt_on_full && trace_run;
  // The triggering instruction itself is recorded
  assign trace_wr = i_cpu_retire && debug_on && i_trace_enable && (trace_run || (trace_armed
                    && (i_cpu_pc == i_trace_trig_addr))) && !(trace_full && i_trace_halt_on_full)
                    && (!i_trace_window_en || in_range(i_cpu_pc, i_trace_lo, i_trace_hi));

  // Write pointer and fill count; clearing i_trace_enable starts a fresh buffer
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wp <= '0;
      o_trace_count <= '0;
      o_trace_wrapped <= 1'b0;
    end
    else if (!i_trace_enable)
    begin
      wp <= '0;
      o_trace_count <= '0;
      o_trace_wrapped <= 1'b0;
    end
    else if (trace_wr)
    begin
      wp <= (wp == depth - 1'b1) ? '0 : wp + 1'b1; // Oldest overwritten
      if (trace_full)
        o_trace_wrapped <= 1'b1;
      else
        o_trace_count <= o_trace_count + 1'b1;
    end
  end

  // Trace storage; no reset, contents valid only below the count
  always_ff @(posedge i_mclk)
  begin
    if (trace_wr && i_trace_pc_only)
    begin
      if (wp[0])
        mem[wp[TRACE_IDX_W-1:1]][2*ADDR_W-1:ADDR_W] <= i_cpu_pc;
      else
        mem[wp[TRACE_IDX_W-1:1]][ADDR_W-1:0] <= i_cpu_pc;
    end
    else if (trace_wr)
      mem[wp[TRACE_WORD_W-1:0]] <= {i_cpu_pc, i_cpu_accum, i_cpu_sel_reg};
    o_trace_word <= mem[i_trace_rd_index];
  end
endmodule : debug_port_access_and_trace
`default_nettype wire

// File: tb/dbg_props.sv
/*
  Concurrent checks on the debug access block's ports.
  Assumes it is bound into the top block and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module dbg_props
  import dbg_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_security_lock,
  input wire logic i_step_req,
  input wire logic i_resume_req,
  input wire logic i_dbg_access_req,
  input wire logic [NUM_BP-1:0] i_bp_en,
  input wire logic [NUM_BP-1:0][ADDR_W-1:0] i_bp_addr,
  input wire logic i_seq_mode,
  input wire logic i_cpu_retire,
  input wire logic [ADDR_W-1:0] i_cpu_pc,
  input wire logic o_jtag_active,
  input wire logic o_swd_on_jtag_pins,
  input wire logic o_swd_on_usb_pins,
  input wire logic o_bscan_allow,
  input wire logic o_viewer_active,
  input wire logic o_debug_on,
  input wire logic o_dbg_access_grant,
  input wire logic o_cpu_halt
);
  logic [NUM_BP-1:0] bp_hit; // Enabled comparators matching the retiring address
  // Breakpoint match per comparator
  always_comb
  begin
    for (int k = 0; k < NUM_BP; k++)
    begin
      bp_hit[k] = i_bp_en[k] && (i_bp_addr[k] == i_cpu_pc);
    end
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  // Halted, debug live, step asked and not overridden by resume
  sequence s_step_go;
    o_cpu_halt && o_debug_on && i_step_req && !i_resume_req;
  endsequence
  // The single stepped instruction retires
  sequence s_one_retire;
    !o_cpu_halt && i_cpu_retire;
  endsequence
  a_one_pair_only: assert property (!(o_swd_on_jtag_pins && o_swd_on_usb_pins))
    else $error("serial port active on both pin pairs");
  a_bscan_test_only: assert property (o_bscan_allow |-> o_jtag_active && !o_swd_on_jtag_pins)
    else $error("boundary scan access outside test port");
  a_grant_needs_debug: assert property (o_dbg_access_grant == (i_dbg_access_req && o_debug_on))
    else $error("access grant does not follow debug enable");
  a_debug_stays_on: assert property (o_debug_on |=> o_debug_on)
    else $error("debug enable dropped without reset");
  a_no_debug_run: assert property (!o_debug_on |=> !o_cpu_halt)
    else $error("cpu halted while debug is off");
  a_halt_holds: assert property (o_cpu_halt && o_debug_on && !i_step_req && !i_resume_req |=> o_cpu_halt)
    else $error("halt released without request");
  a_step_release: assert property (s_step_go |=> !o_cpu_halt)
    else $error("step did not release the cpu");
  a_step_rehalt: assert property (s_step_go ##1 s_one_retire |=> o_cpu_halt)
    else $error("cpu not halted after one stepped instruction");
  a_bp_stops_cpu: assert property (!o_cpu_halt && o_debug_on && !i_seq_mode && i_cpu_retire && |bp_hit
    |=> o_cpu_halt)
    else $error("breakpoint hit did not halt");
  a_viewer_serial_only: assert property (o_viewer_active |-> !o_jtag_active)
    else $error("viewer active beside test port");
  a_lock_all_quiet: assert property (i_security_lock && $past(i_security_lock) && !$past(i_rst)
    |-> !o_debug_on && !o_jtag_active && !o_swd_on_usb_pins && !o_swd_on_jtag_pins)
    else $error("access open while locked");
endmodule : dbg_props
bind debug_port_access_and_trace dbg_props props (.i_mclk, .i_rst, .i_security_lock, .i_step_req, .i_resume_req,
  .i_dbg_access_req, .i_bp_en, .i_bp_addr, .i_seq_mode, .i_cpu_retire, .i_cpu_pc, .o_jtag_active,
  .o_swd_on_jtag_pins, .o_swd_on_usb_pins, .o_bscan_allow, .o_viewer_active, .o_debug_on, .o_dbg_access_grant,
  .o_cpu_halt);
`default_nettype wire

// File: tb/swd_debugger_model.sv
/*
  External debugger on one serial pin pair: clock plus data.
  Assumes the bench resolves the data wire against the block's own drive.
*/
`timescale 1ns/1ns
`default_nettype none
module swd_debugger_model
  import dbg_pkg::*;
(
  output var logic o_pin_clk,
  output var logic o_pin_data
);
  localparam int HALF_LO = 63; // 125 ns period, never above 8 MHz
  localparam int HALF_HI = 62;
  // Idle: clock stands still, data parked
  initial
  begin
    o_pin_clk = 1'b0;
    o_pin_data = 1'b1;
  end
  // Key MSB first, data moved while clock is low
  task automatic send_key(input logic [KEY_LEN-1:0] key);
    for (int i = KEY_LEN - 1; i >= 0; i--)
    begin
      o_pin_data = key[i];
      #HALF_LO o_pin_clk = 1'b1;
      #HALF_HI o_pin_clk = 1'b0;
    end
    // Released line must not look like held data
    o_pin_data = ~o_pin_data;
  endtask : send_key
endmodule : swd_debugger_model
`default_nettype wire

// File: tb/debug_port_access_and_trace_test.sv
/*
  Self-checking bench for the debug access block.
  Assumes two debugger models drive the test pair and the USB pair.
*/
`timescale 1ns/1ns
`default_nettype none
module debug_port_access_and_trace_test
  import dbg_pkg::*;
;
  logic i_mclk, i_rst, i_tck, i_usb_dm_in, tms_line, dp_line;
  logic i_security_lock, i_jtag_cfg_disable, i_trst_used, i_fw_debug_enable, i_jtag_disable, i_jtag_swd_enable;
  logic i_swd_disable, i_swd_jtag_enable, i_viewer_enable, i_viewer_bit, i_jtag_tdo, i_swd_dout, i_swd_doe;
  logic i_halt_req, i_step_req, i_resume_req, i_dbg_access_req, i_seq_mode, i_mbp_en, i_cpu_retire, i_mem_access;
  logic i_trace_enable, i_trace_pc_only, i_trace_window_en, i_trace_halt_on_full;
  logic [NUM_BP-1:0] i_bp_en;
  logic [NUM_BP-1:0][ADDR_W-1:0] i_bp_addr;
  logic [SEQ_W-1:0] i_seq_last;
  logic [ADDR_W-1:0] i_mbp_addr, i_cpu_pc, i_mem_addr, i_trace_trig_addr, i_trace_lo, i_trace_hi;
  logic [DATA_W-1:0] i_mbp_data, i_cpu_accum, i_cpu_sel_reg, i_mem_data;
  logic [TRACE_WORD_W-1:0] i_trace_rd_index;
  logic o_tms_out, o_tms_oe, o_usb_dp_out, o_usb_dp_oe, o_jtag_active, o_swd_on_jtag_pins, o_swd_on_usb_pins;
  logic o_bscan_allow, o_viewer_active, o_tck_overrate, o_debug_on, o_dbg_access_grant, o_cpu_halt;
  logic [2:0] o_gpio_claim;
  int tests_run = 0; // Comparisons made
  int miscompares = 0; // Comparisons failed
  // Shared data wires: the block wins while it drives
  wire i_tms_in = o_tms_oe ? o_tms_out : tms_line;
  wire i_usb_dp_in = o_usb_dp_oe ? o_usb_dp_out : dp_line;
  swd_debugger_model jtag_dbg (.o_pin_clk(i_tck), .o_pin_data(tms_line));
  swd_debugger_model usb_dbg (.o_pin_clk(i_usb_dm_in), .o_pin_data(dp_line));
  debug_port_access_and_trace dut (.i_mclk, .i_rst, .i_tck, .i_tms_in, .o_tms_out, .o_tms_oe, .o_tdo(), .o_tdo_oe(),
    .i_usb_dm_in, .i_usb_dp_in, .o_usb_dp_out, .o_usb_dp_oe, .i_security_lock, .i_jtag_cfg_disable, .i_trst_used,
    .i_fw_debug_enable, .i_jtag_disable, .i_jtag_swd_enable, .i_swd_disable, .i_swd_jtag_enable, .i_viewer_enable,
    .i_viewer_bit, .i_jtag_tdo, .i_swd_dout, .i_swd_doe, .o_swd_clk_rise(), .o_swd_din(), .o_jtag_active,
    .o_swd_on_jtag_pins, .o_swd_on_usb_pins, .o_bscan_allow, .o_viewer_active, .o_gpio_claim, .o_tck_overrate,
    .o_debug_on, .i_halt_req, .i_step_req, .i_resume_req, .i_dbg_access_req, .o_dbg_access_grant, .i_bp_en,
    .i_bp_addr, .i_seq_mode, .i_seq_last, .i_mbp_en, .i_mbp_addr, .i_mbp_data, .i_cpu_retire, .i_cpu_pc,
    .i_cpu_accum, .i_cpu_sel_reg, .i_mem_access, .i_mem_addr, .i_mem_data, .o_cpu_halt, .i_trace_enable,
    .i_trace_pc_only, .i_trace_trig_addr, .i_trace_window_en, .i_trace_lo, .i_trace_hi, .i_trace_halt_on_full,
    .i_trace_rd_index, .o_trace_word(), .o_trace_count(), .o_trace_wrapped());
  // 100 MHz system clock
  always #5 i_mclk = ~i_mclk;
  // Inputs move 1 ns after the edge, away from sampling
  task automatic tick;
    @(posedge i_mclk);
    #1;
  endtask : tick
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : check
  task automatic end_sim;
    $display("compares %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  // One-cycle command pulse, then let the answer settle
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick;
    s = 1'b0;
    repeat (2) tick;
  endtask : pulse
  task automatic retire(input logic [ADDR_W-1:0] pc);
    i_cpu_pc = pc;
    i_cpu_retire = 1'b1;
    tick;
    i_cpu_retire = 1'b0;
    tick;
  endtask : retire
  task automatic do_reset(input logic lock);
    i_security_lock = lock;
    i_rst = 1'b1;
    repeat (5) tick;
    i_rst = 1'b0;
    repeat (2) tick;
  endtask : do_reset
  // Fresh device: test port on, pin count by reset line use
  task automatic s_reset_state;
    do_reset(1'b0);
    check("jtag_active", o_jtag_active, 8'h1);
    check("claim", o_gpio_claim, 8'h4);
    i_trst_used = 1'b1;
    repeat (2) tick;
    check("claim", o_gpio_claim, 8'h5);
    i_trst_used = 1'b0;
  endtask : s_reset_state
  // Key on USB pair, then a second key on the test pair is refused
  task automatic s_usb_key;
    usb_dbg.send_key(KEY_SEQ);
    repeat (10) tick;
    check("usb_pins", o_swd_on_usb_pins, 8'h1);
    pulse(i_jtag_swd_enable);
    check("jtag_pins", o_swd_on_jtag_pins, 8'h0);
    jtag_dbg.send_key(KEY_SEQ);
    repeat (10) tick;
    check("jtag_pins", o_swd_on_jtag_pins, 8'h0);
  endtask : s_usb_key
  task automatic s_debug;
    i_dbg_access_req = 1'b1;
    pulse(i_halt_req);
    check("halt", o_cpu_halt, 8'h0);
    check("grant", o_dbg_access_grant, 8'h0);
    pulse(i_fw_debug_enable);
    check("grant", o_dbg_access_grant, 8'h1);
    pulse(i_halt_req);
    check("halt", o_cpu_halt, 8'h1);
    i_step_req = 1'b1;
    tick;
    i_step_req = 1'b0;
    check("stepping", o_cpu_halt, 8'h0);
    retire(16'h0050);
    check("stepped", o_cpu_halt, 8'h1);
    pulse(i_resume_req);
    retire(16'h0122);
    check("near_miss", o_cpu_halt, 8'h0);
    retire(16'h0123);
    check("bp_hit", o_cpu_halt, 8'h1);
    pulse(i_resume_req);
  endtask : s_debug
  // Late key refused; port handover through commands
  task automatic s_late_key;
    do_reset(1'b0);
    repeat (820) tick;
    jtag_dbg.send_key(KEY_SEQ);
    repeat (10) tick;
    check("late_key", o_swd_on_jtag_pins, 8'h0);
    check("overrate", o_tck_overrate, 8'h0);
    pulse(i_jtag_swd_enable);
    check("jtag_pins", o_swd_on_jtag_pins, 8'h1);
    check("bscan", o_bscan_allow, 8'h0);
    check("claim", o_gpio_claim, 8'h2);
    i_viewer_enable = 1'b1;
    repeat (2) tick;
    check("viewer", o_viewer_active, 8'h1);
    check("claim", o_gpio_claim, 8'h3);
    pulse(i_swd_jtag_enable);
    check("jtag_back", o_jtag_active, 8'h1);
    check("viewer", o_viewer_active, 8'h0);
    i_viewer_enable = 1'b0;
    pulse(i_jtag_disable);
    check("jtag_off", o_jtag_active, 8'h0);
    check("claim", o_gpio_claim, 8'h0);
  endtask : s_late_key
  task automatic s_locked;
    do_reset(1'b1);
    usb_dbg.send_key(KEY_SEQ);
    repeat (10) tick;
    check("usb_pins", o_swd_on_usb_pins, 8'h0);
    check("jtag_active", o_jtag_active, 8'h0);
    pulse(i_fw_debug_enable);
    check("debug_on", o_debug_on, 8'h0);
  endtask : s_locked
  // Watchdog: the full run needs about 17 us
  initial
  begin
    #100000;
    miscompares++;
    end_sim;
  end
  initial
  begin
    i_mclk = 1'b0;
    i_rst = 1'b1;
    {i_security_lock, i_jtag_cfg_disable, i_trst_used, i_fw_debug_enable, i_jtag_disable, i_jtag_swd_enable,
      i_swd_disable, i_swd_jtag_enable, i_viewer_enable, i_viewer_bit, i_jtag_tdo, i_swd_dout, i_swd_doe,
      i_halt_req, i_step_req, i_resume_req, i_dbg_access_req, i_seq_mode, i_mbp_en, i_cpu_retire, i_mem_access,
      i_trace_enable, i_trace_pc_only, i_trace_window_en, i_trace_halt_on_full, i_seq_last, i_mbp_addr, i_cpu_pc,
      i_mem_addr, i_trace_trig_addr, i_trace_lo, i_trace_hi, i_mbp_data, i_cpu_accum, i_cpu_sel_reg, i_mem_data,
      i_trace_rd_index} = '0;
    i_bp_addr = '0;
    i_bp_addr[3] = 16'h0123;
    i_bp_en = 8'h08;
    s_reset_state;
    s_usb_key;
    s_debug;
    s_late_key;
    s_locked;
    end_sim;
  end
endmodule : debug_port_access_and_trace_test
`default_nettype wire
